// file: iceb_pkg.sv
package iceb_pkg;

  localparam int          NUM_CH        = 32;
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OFF_ENABLE    = 12'h500;
  localparam logic [11:0] OFF_SET       = 12'h504;
  localparam logic [11:0] OFF_CLEAR     = 12'h508;
  localparam logic [31:0] RESET_ENABLE  = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  typedef enum logic [1:0] {
    ICEB_OP_NONE,
    ICEB_OP_WRITE,
    ICEB_OP_SET,
    ICEB_OP_CLEAR
  } iceb_op_t;

  typedef struct packed {
    logic [11:0] address;
    logic [3:0]  byteenable;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } iceb_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  response;
  } iceb_rsp_t;

  localparam logic [1:0] RESP_OK    = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: iceb_gate.sv
`timescale 1ns/1ps
// registered event gating, one enable bit per channel
module iceb_gate
(
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [31:0] enable_i,
  input  wire logic [31:0] event_i,
  output logic      [31:0] task_o
);

  logic [31:0] task_reg;
  logic [31:0] task_next;

  always_comb
  begin
    task_next = event_i & enable_i;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      task_reg <= 32'h00000000;
    else
      task_reg <= task_next;
  end

  assign task_o = task_reg;

  a_gate_blocks : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    1'b1 |=> ((task_o & ~$past(enable_i)) == 32'h00000000))
    else $error("task passed on disabled channel");

  a_gate_passes : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    1'b1 |=> (task_o == ($past(event_i) & $past(enable_i))))
    else $error("enabled event not forwarded");

endmodule

// file: iceb_top.sv
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - 32-bit enable register, bit n is channel n
// - set alias decoded at 0x504, same bits
// - set alias reads current enable bits
// - set alias: ones enable, zeros unchanged
// - clear alias 0x508: reads bits, ones disable
module iceb_top
(
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [11:0] avs_address_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic      [1:0]  avs_response_o,
  input  wire logic [31:0] event_i,
  output logic      [31:0] task_o,
  output logic      [31:0] channel_enable_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // byte-enable expansion and address decode

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic iceb_pkg::iceb_op_t decode(input logic [11:0] a);
    if (a == iceb_pkg::OFF_ENABLE)
      decode = iceb_pkg::ICEB_OP_WRITE;
    else if (a == iceb_pkg::OFF_SET)
      decode = iceb_pkg::ICEB_OP_SET;
    else if (a == iceb_pkg::OFF_CLEAR)
      decode = iceb_pkg::ICEB_OP_CLEAR;
    else
      decode = iceb_pkg::ICEB_OP_NONE;
  endfunction

  iceb_pkg::iceb_req_t req;
  iceb_pkg::iceb_rsp_t rsp_reg;
  iceb_pkg::iceb_rsp_t rsp_next;
  iceb_pkg::iceb_op_t  op;
  logic [31:0]         enable_reg;
  logic [31:0]         enable_next;
  logic [31:0]         wmask;
  logic                ack_reg;
  logic                ack_next;

  assign req = '{address: avs_address_i, byteenable: avs_byteenable_i,
                 read: avs_read_i, write: avs_write_i, writedata: avs_writedata_i};
  assign op    = decode(req.address);
  assign wmask = be_mask(req.byteenable);

  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake: every access waits one cycle, answered on the second edge

  always_comb
  begin
    ack_next = 1'b0;
    rsp_next = '{readdata: 32'h00000000, waitrequest: 1'b1, response: iceb_pkg::RESP_OK};
    if ((req.read || req.write) && !ack_reg)
    begin
      ack_next             = 1'b1;
      rsp_next.waitrequest = 1'b0;
      if (op == iceb_pkg::ICEB_OP_NONE)
      begin
        rsp_next.readdata = iceb_pkg::UNMAPPED_READ;
        rsp_next.response = iceb_pkg::RESP_SLVERR;
      end
      else if (req.read)
        rsp_next.readdata = enable_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel enable bits; write takes effect on the answering edge

  always_comb
  begin
    enable_next = enable_reg;
    if (req.write && ack_reg)
    begin
      unique case (op)
        iceb_pkg::ICEB_OP_WRITE:
          enable_next = (enable_reg & ~wmask) | (req.writedata & wmask);
        iceb_pkg::ICEB_OP_SET:
          enable_next = enable_reg | (req.writedata & wmask);
        iceb_pkg::ICEB_OP_CLEAR:
          enable_next = enable_reg & ~(req.writedata & wmask);
        iceb_pkg::ICEB_OP_NONE:
          enable_next = enable_reg;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      enable_reg <= iceb_pkg::RESET_ENABLE;
      ack_reg    <= 1'b0;
      rsp_reg    <= '{readdata: 32'h00000000, waitrequest: 1'b1,
                      response: iceb_pkg::RESP_OK};
    end
    else
    begin
      enable_reg <= enable_next;
      ack_reg    <= ack_next;
      rsp_reg    <= rsp_next;
    end
  end

  assign avs_readdata_o    = rsp_reg.readdata;
  assign avs_waitrequest_o = rsp_reg.waitrequest;
  assign avs_response_o    = rsp_reg.response;
  assign channel_enable_o  = enable_reg;

  iceb_gate u_gate
  (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .enable_i  (enable_reg),
    .event_i   (event_i),
    .task_o    (task_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  logic done;
  assign done = !avs_waitrequest_o && (avs_read_i || avs_write_i);

  a_write_direct : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    done && avs_write_i && avs_address_i == iceb_pkg::OFF_ENABLE
      && avs_byteenable_i == 4'hF |=> channel_enable_o == $past(avs_writedata_i))
    else $error("direct write not stored");

  a_set_ones : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    done && avs_write_i && avs_address_i == iceb_pkg::OFF_SET && avs_byteenable_i == 4'hF
      |=> channel_enable_o == ($past(channel_enable_o) | $past(avs_writedata_i)))
    else $error("set alias wrong");

  a_clear_ones : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    done && avs_write_i && avs_address_i == iceb_pkg::OFF_CLEAR && avs_byteenable_i == 4'hF
      |=> channel_enable_o == ($past(channel_enable_o) & ~$past(avs_writedata_i)))
    else $error("clear alias wrong");

  a_set_read : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    done && avs_read_i && (avs_address_i == iceb_pkg::OFF_SET
      || avs_address_i == iceb_pkg::OFF_CLEAR || avs_address_i == iceb_pkg::OFF_ENABLE)
      |-> avs_readdata_o == channel_enable_o)
    else $error("alias read mismatch");

  a_alias_decode : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    done && avs_address_i == iceb_pkg::OFF_SET |-> avs_response_o == iceb_pkg::RESP_OK)
    else $error("set alias not decoded");

  a_hold_idle : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !(done && avs_write_i) |=> $stable(channel_enable_o))
    else $error("enable changed without write");

  a_answer_bound : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $rose(avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o)
    else $error("no answer within one cycle");

  logic mapped;
  assign mapped = (avs_address_i == iceb_pkg::OFF_ENABLE) || (avs_address_i == iceb_pkg::OFF_SET)
    || (avs_address_i == iceb_pkg::OFF_CLEAR);

  a_mapped_ok : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    done && mapped
      |-> avs_response_o == iceb_pkg::RESP_OK)
    else $error("mapped access not answered okay");

  a_unmapped_err : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    done && !mapped
      |-> avs_response_o == iceb_pkg::RESP_SLVERR && avs_readdata_o == iceb_pkg::UNMAPPED_READ)
    else $error("unmapped access not refused");

  a_unmapped_hold : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    done && avs_write_i && !mapped
      |=> $stable(channel_enable_o))
    else $error("unmapped write changed enables");

  a_set_no_clear : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    done && avs_write_i && avs_address_i == iceb_pkg::OFF_SET
      |=> ($past(channel_enable_o) & ~channel_enable_o) == 32'h00000000)
    else $error("set alias cleared a channel");

  a_clear_no_set : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    done && avs_write_i && avs_address_i == iceb_pkg::OFF_CLEAR
      |=> (channel_enable_o & ~$past(channel_enable_o)) == 32'h00000000)
    else $error("clear alias enabled a channel");

  a_wait_release : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !avs_waitrequest_o
      |=> avs_waitrequest_o)
    else $error("answer stood more than one cycle");

  a_idle_data : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    avs_waitrequest_o
      |-> avs_readdata_o == 32'h00000000)
    else $error("read data not zero while waiting");

  ////////////////////////////////////////////////////////////////////////////////
  // scenario covers

  c_set_write  : cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    done && avs_write_i && avs_address_i == iceb_pkg::OFF_SET);
  c_clr_write  : cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    done && avs_write_i && avs_address_i == iceb_pkg::OFF_CLEAR);
  c_set_read   : cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    done && avs_read_i && avs_address_i == iceb_pkg::OFF_SET);
  c_task_fired : cover property (@(posedge sys_clk_i) disable iff (!rstn_i) task_o != 32'h0);
  c_unmapped   : cover property (@(posedge sys_clk_i) disable iff (!rstn_i) done && !mapped);

endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk_i;
  logic        rstn_i;
  logic [11:0] avs_address_i;
  logic [3:0]  avs_byteenable_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [1:0]  avs_response_o;
  logic [31:0] event_i;
  logic [31:0] task_o;
  logic [31:0] channel_enable_o;
  int          miscompares;
  int          checked;
  iceb_top iceb_top_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .event_i(event_i), .task_o(task_o), .channel_enable_o(channel_enable_o));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic close_out;
    $display("miscompares=%0d checked=%0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      miscompares++;
    end
  endtask
  // one access; holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [3:0] be,
                     input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_address_i    <= a;
    avs_byteenable_i <= be;
    avs_writedata_i  <= d;
    avs_write_i      <= wr;
    avs_read_i       <= ~wr;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    r = avs_response_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 50)
    begin
      $display("BAD %0t no answer on the bus", $time);
      miscompares++;
    end
  endtask
  task automatic wr_ok(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b1, a, be, d, q, r);
    chk({30'h0, r}, {30'h0, iceb_pkg::RESP_OK}, "write response");
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b0, a, 4'hF, 32'h0, q, r);
    chk(q, exp, "read data");
    chk({30'h0, r}, {30'h0, iceb_pkg::RESP_OK}, "read response");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(channel_enable_o, iceb_pkg::RESET_ENABLE, "reset enable");
    rd_chk(iceb_pkg::OFF_ENABLE, iceb_pkg::RESET_ENABLE);
    rd_chk(iceb_pkg::OFF_SET, iceb_pkg::RESET_ENABLE);
    rd_chk(iceb_pkg::OFF_CLEAR, iceb_pkg::RESET_ENABLE);
  endtask
  task automatic t_regs;
    wr_ok(iceb_pkg::OFF_ENABLE, 4'hF, 32'h80000101);
    rd_chk(iceb_pkg::OFF_SET, 32'h80000101);
    chk(channel_enable_o, 32'h80000101, "direct write");
    // upper lanes masked, so bit 16 must stay off and bit 31 stays on
    wr_ok(iceb_pkg::OFF_SET, 4'h3, 32'h00010002);
    rd_chk(iceb_pkg::OFF_SET, 32'h80000103);
    wr_ok(iceb_pkg::OFF_CLEAR, 4'hF, 32'h80000001);
    rd_chk(iceb_pkg::OFF_CLEAR, 32'h00000102);
    wr_ok(iceb_pkg::OFF_SET, 4'hF, 32'h00000000);
    @(negedge sys_clk_i);
    chk(channel_enable_o, 32'h00000102, "zeros leave bits");
  endtask
  task automatic t_unmapped;
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b1, 12'h50C, 4'hF, 32'hFFFFFFFF, q, r);
    @(negedge sys_clk_i);
    chk(channel_enable_o, 32'h00000102, "unmapped write");
    chk({30'h0, r}, {30'h0, iceb_pkg::RESP_SLVERR}, "unmapped write response");
    bus(1'b0, 12'h50C, 4'hF, 32'h0, q, r);
    chk(q, iceb_pkg::UNMAPPED_READ, "unmapped data");
    chk({30'h0, r}, {30'h0, iceb_pkg::RESP_SLVERR}, "unmapped response");
  endtask
  task automatic t_rerun;
    @(posedge sys_clk_i);
    rstn_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(channel_enable_o, iceb_pkg::RESET_ENABLE, "enable in reset");
    chk(task_o, 32'h00000000, "task in reset");
    chk({31'h0, avs_waitrequest_o}, 32'h00000001, "wait in reset");
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    rd_chk(iceb_pkg::OFF_SET, iceb_pkg::RESET_ENABLE);
  endtask
  task automatic t_gate;
    @(posedge sys_clk_i);
    event_i <= 32'hFFFFFFFF;
    @(posedge sys_clk_i);
    event_i <= 32'h00000000;
    @(negedge sys_clk_i);
    chk(task_o, 32'h00000102, "gated events");
    @(negedge sys_clk_i);
    chk(task_o, 32'h00000000, "no events");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    miscompares      = 0;
    checked          = 0;
    rstn_i           = 1'b0;
    avs_address_i    = 12'h000;
    avs_byteenable_i = 4'h0;
    avs_read_i       = 1'b0;
    avs_write_i      = 1'b0;
    avs_writedata_i  = 32'h00000000;
    event_i          = 32'h00000000;
    repeat (8) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_regs();
    t_unmapped();
    t_gate();
    t_rerun();
    close_out();
  end
  initial
  begin
    repeat (2000) @(posedge sys_clk_i);
    miscompares++;
    close_out();
  end
endmodule
